/* hw/reason_event_regs.svh */
// constants for the reason code selector and event packet builder
`ifndef REASON_EVENT_REGS_SVH
`define REASON_EVENT_REGS_SVH

// reason codes
`define RC_NONE 16'h0000
`define RC_INIT 16'h0001
`define RC_PARAM 16'h0002
`define RC_CHAN_NR 16'h0003
`define RC_PKG_NR 16'h0004
`define RC_LEN 16'h0005
`define RC_INFO 16'h0006
`define RC_UNSUP 16'h7fff
`define RC_VENDOR_BIT 15

// response codes
`define RSP_OK 16'h0000
`define RSP_UNSUP 16'h0003
`define RSP_DELAYED 16'h0004

// command types
`define CMD_CLEAR_INIT 8'h00
`define CMD_SEL_PKG 8'h01
`define CMD_DESEL_PKG 8'h02
`define CMD_RESET_CHAN 8'h05

// event packet fields
`define EVT_MGR_ID 8'h00
`define EVT_HDR_REV 8'h01
`define EVT_INST_ID 8'h00
`define EVT_MSG_TYPE 8'hff
`define EVT_LEN_STD 8'h08
`define EVT_LEN_OEM 8'h0c

// event type codes
`define EVT_LINK 8'h00
`define EVT_CFG_REQ 8'h01
`define EVT_DRV_CHG 8'h02
`define EVT_DLY_RDY 8'h03
`define EVT_RSV_LO 8'h04
`define EVT_RSV_HI 8'h6f

// word indices within a packet
`define W_HDR0 3'h0
`define W_HDR1 3'h1
`define W_RSV0 3'h2
`define W_RSV1 3'h3
`define W_TYPE 3'h4
`define W_FIELD5 3'h5
`define W_FIELD6 3'h6
`define W_LAST_STD 3'h6
`define W_LAST_OEM 3'h7

`endif

/* hw/reason_event_pkg.sv */
// types shared by the reason code selector and event packet builder
package reason_event_pkg;
  typedef enum logic {
    PKT_IDLE,
    PKT_SEND
  } pkt_state_e;
  typedef logic [31:0] word_t;
endpackage

/* hw/csum_acc.sv */
// checksum step: adds both 16-bit halves of a word and forms the final check word
`timescale 1ns/100ps
`default_nettype none
module csum_acc (
  input wire logic [31:0] sum_in,
  input wire logic [31:0] word_in,
  output logic [31:0] sum_out,
  output logic [31:0] csum_out
);
  // -------------------------------------------------------------
  // ones of 16-bit words summed into 32 bits, then negated
  // -------------------------------------------------------------
  assign sum_out = sum_in + {16'h0000, word_in[31:16]} + {16'h0000, word_in[15:0]};
  assign csum_out = (~sum_in) + 32'h0000_0001;
endmodule // csum_acc
`default_nettype wire

/* hw/reason_code_and_event_packet_builder.sv */
// reason code selection for responses and event notification packet framing
//
// Contract
// [RULE1] reason zero: normal completion with success, otherwise no extra detail
// [RULE2] in initial state answer all but package select/deselect with reason one; the code also exempts clear-initial-state
// [RULE3] out-of-range parameter gives reason two
// [RULE4] channel transient condition may give reason three
// [RULE5] package transient condition may give reason four
// [RULE6] wrong payload length gives reason five
// [RULE7] valid command without available data gives reason six
// [RULE8] unknown command gives 0x7fff, paired only with command-unsupported response
// [RULE9] reason codes with top bit set are vendor defined
// [RULE10] event packets follow the general control message layout
// [RULE11] event instance identifier is zero; manager never acknowledges events
// [RULE12] event control message type field is 0xff
// [RULE13] event carries the device's own channel identifier
// [RULE14] 8-bit event type sits in low byte of bytes 16 to 19
// [RULE15] event type encodings; reserved range 0x04 to 0x6f is not sent
// [RULE16] standard event: data bytes 20-23, checksum 24-27, bytes 8-15 reserved
// [RULE17] oem event: manufacturer id 20-23, data 24-27, checksum 28-31
// [RULE18] delayed-response response code always carries reason zero
// [RULE19] checksum covers all earlier bytes; reserved fields are zero
`timescale 1ns/100ps
`default_nettype none
`include "reason_event_regs.svh"
module reason_code_and_event_packet_builder
  import reason_event_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // response side
  input wire logic resp_req,
  input wire logic [7:0] cmd_type,
  input wire logic [15:0] resp_code_in,
  input wire logic cmd_unknown,
  input wire logic param_bad,
  input wire logic len_bad,
  input wire logic chan_busy,
  input wire logic pkg_busy,
  input wire logic info_na,
  input wire logic [15:0] vendor_reason,
  output logic resp_valid_q,
  output logic [15:0] resp_code_q,
  output logic [15:0] reason_code_q,
  output logic chan_initial_q,
  // event side
  input wire logic evt_req,
  input wire logic evt_oem,
  input wire logic [7:0] event_type_code,
  input wire logic [31:0] evt_data,
  input wire logic [31:0] mfr_id,
  input wire logic [7:0] own_chan_id,
  output logic evt_busy_q,
  output logic evt_reject_q,
  output logic pkt_valid_q,
  output logic [31:0] pkt_word_q,
  output logic pkt_last_q,
  input wire logic pkt_ready
);

  // -------------------------------------------------------------
  // reason code selection
  // -------------------------------------------------------------
  logic resp_valid_d;
  logic [15:0] resp_code_d;
  logic [15:0] reason_code_d;
  logic chan_initial_d;
  logic init_exempt;

  always_comb begin
    resp_valid_d = 1'b0;
    resp_code_d = resp_code_q;
    reason_code_d = reason_code_q;
    chan_initial_d = chan_initial_q;
    // clear-initial-state is the acknowledgement itself, so it is exempt too
    init_exempt = (cmd_type == `CMD_SEL_PKG) || (cmd_type == `CMD_DESEL_PKG) ||
                  (cmd_type == `CMD_CLEAR_INIT);
    if (resp_req) begin
      resp_valid_d = 1'b1;
      resp_code_d = resp_code_in;
      if (cmd_unknown) begin
        resp_code_d = `RSP_UNSUP; // [RULE8]
        reason_code_d = `RC_UNSUP; // [RULE8]
      end else if (resp_code_in == `RSP_DELAYED) begin
        reason_code_d = `RC_NONE; // [RULE18]
      end else if (chan_initial_q && !init_exempt) begin
        reason_code_d = `RC_INIT; // [RULE2]
      end else if (len_bad) begin
        reason_code_d = `RC_LEN; // [RULE6]
      end else if (param_bad) begin
        reason_code_d = `RC_PARAM; // [RULE3]
      end else if (pkg_busy) begin
        reason_code_d = `RC_PKG_NR; // [RULE5]
      end else if (chan_busy) begin
        reason_code_d = `RC_CHAN_NR; // [RULE4]
      end else if (info_na) begin
        reason_code_d = `RC_INFO; // [RULE7]
      end else if (vendor_reason[`RC_VENDOR_BIT]) begin
        // only upper-half values pass, so a vendor code never aliases a standard one
        reason_code_d = vendor_reason; // [RULE9]
      end else begin
        reason_code_d = `RC_NONE; // [RULE1]
      end
      // initial state ends on clear, restarts on channel reset
      if (!cmd_unknown && cmd_type == `CMD_CLEAR_INIT) begin
        chan_initial_d = 1'b0; // [RULE2]
      end else if (!cmd_unknown && cmd_type == `CMD_RESET_CHAN) begin
        chan_initial_d = 1'b1; // [RULE2]
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid_q <= 1'b0;
      resp_code_q <= `RSP_OK;
      reason_code_q <= `RC_NONE;
      chan_initial_q <= 1'b1;
    end else if (clk_en) begin
      resp_valid_q <= resp_valid_d;
      resp_code_q <= resp_code_d;
      reason_code_q <= reason_code_d;
      chan_initial_q <= chan_initial_d;
    end
  end

  // -------------------------------------------------------------
  // event packet framing
  // -------------------------------------------------------------
  pkt_state_e state_q;
  pkt_state_e state_d;
  logic [2:0] idx_q;
  logic [2:0] idx_d;
  logic [2:0] out_idx_q;
  logic [2:0] out_idx_d;
  logic oem_q;
  logic oem_d;
  logic [7:0] type_q;
  logic [7:0] type_d;
  logic [31:0] data_q;
  logic [31:0] data_d;
  logic [31:0] mfr_q;
  logic [31:0] mfr_d;
  logic [7:0] chan_q;
  logic [7:0] chan_d;
  word_t sum_q;
  word_t sum_d;
  word_t sum_next;
  word_t csum;
  word_t word_sel;
  logic pkt_valid_d;
  logic [31:0] pkt_word_d;
  logic pkt_last_d;
  logic evt_busy_d;
  logic evt_reject_d;
  logic can_load;
  logic is_last;
  logic type_reserved;

  csum_acc u_csum (
    .sum_in(sum_q),
    .word_in(word_sel),
    .sum_out(sum_next),
    .csum_out(csum)
  );

  // word chosen for the current index
  always_comb begin
    is_last = oem_q ? (idx_q == `W_LAST_OEM) : (idx_q == `W_LAST_STD);
    case (idx_q)
      `W_HDR0: word_sel = {`EVT_MGR_ID, `EVT_HDR_REV, 8'h00, `EVT_INST_ID}; // [RULE10] [RULE11]
      `W_HDR1: word_sel = {`EVT_MSG_TYPE, chan_q, 8'h00,
                           oem_q ? `EVT_LEN_OEM : `EVT_LEN_STD}; // [RULE12] [RULE13]
      `W_RSV0: word_sel = 32'h0000_0000; // [RULE16] [RULE19]
      `W_RSV1: word_sel = 32'h0000_0000; // [RULE16] [RULE19]
      `W_TYPE: word_sel = {24'h00_0000, type_q}; // [RULE14]
      `W_FIELD5: word_sel = oem_q ? mfr_q : data_q; // [RULE16] [RULE17]
      `W_FIELD6: word_sel = oem_q ? data_q : csum; // [RULE16] [RULE17]
      default: word_sel = csum; // [RULE17] [RULE19]
    endcase
  end

  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    out_idx_d = out_idx_q;
    oem_d = oem_q;
    type_d = type_q;
    data_d = data_q;
    mfr_d = mfr_q;
    chan_d = chan_q;
    sum_d = sum_q;
    pkt_valid_d = pkt_valid_q;
    pkt_word_d = pkt_word_q;
    pkt_last_d = pkt_last_q;
    evt_reject_d = 1'b0;
    // reserved codes are refused rather than sent
    type_reserved = (event_type_code >= `EVT_RSV_LO) && (event_type_code <= `EVT_RSV_HI);
    can_load = !pkt_valid_q || pkt_ready;
    case (state_q)
      PKT_IDLE: begin
        if (pkt_valid_q && pkt_ready) begin
          pkt_valid_d = 1'b0;
          pkt_last_d = 1'b0;
        end
        if (evt_req && type_reserved) begin
          evt_reject_d = 1'b1; // [RULE15]
        end else if (evt_req) begin
          state_d = PKT_SEND;
          idx_d = `W_HDR0;
          oem_d = evt_oem;
          type_d = event_type_code;
          data_d = evt_data;
          mfr_d = mfr_id;
          chan_d = own_chan_id; // [RULE13]
          sum_d = 32'h0000_0000;
        end
      end
      PKT_SEND: begin
        if (can_load) begin
          pkt_valid_d = 1'b1;
          pkt_word_d = word_sel;
          pkt_last_d = is_last;
          out_idx_d = idx_q;
          sum_d = sum_next; // [RULE19]
          idx_d = idx_q + 3'h1;
          if (is_last) begin
            state_d = PKT_IDLE;
          end
        end
      end
      default: begin
        state_d = PKT_IDLE;
      end
    endcase
    evt_busy_d = (state_d != PKT_IDLE);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PKT_IDLE;
      idx_q <= `W_HDR0;
      out_idx_q <= `W_HDR0;
      oem_q <= 1'b0;
      type_q <= 8'h00;
      data_q <= 32'h0000_0000;
      mfr_q <= 32'h0000_0000;
      chan_q <= 8'h00;
      sum_q <= 32'h0000_0000;
      pkt_valid_q <= 1'b0;
      pkt_word_q <= 32'h0000_0000;
      pkt_last_q <= 1'b0;
      evt_busy_q <= 1'b0;
      evt_reject_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      idx_q <= idx_d;
      out_idx_q <= out_idx_d;
      oem_q <= oem_d;
      type_q <= type_d;
      data_q <= data_d;
      mfr_q <= mfr_d;
      chan_q <= chan_d;
      sum_q <= sum_d;
      pkt_valid_q <= pkt_valid_d;
      pkt_word_q <= pkt_word_d;
      pkt_last_q <= pkt_last_d;
      evt_busy_q <= evt_busy_d;
      evt_reject_q <= evt_reject_d;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_delayed_zero: assert property ( // [RULE18]
    resp_valid_q && resp_code_q == `RSP_DELAYED |-> reason_code_q == `RC_NONE
  ) else $error("delayed response with nonzero reason");

  a_unsup_pairing: assert property ( // [RULE8]
    resp_valid_q && reason_code_q == `RC_UNSUP |-> resp_code_q == `RSP_UNSUP
  ) else $error("unsupported reason without unsupported response");

  a_unknown_cmd: assert property ( // [RULE8]
    clk_en && resp_req && cmd_unknown |=> resp_valid_q && reason_code_q == `RC_UNSUP
  ) else $error("unknown command not answered with unsupported reason");

  a_init_reason: assert property ( // [RULE2]
    clk_en && resp_req && chan_initial_q && !cmd_unknown && !init_exempt &&
    resp_code_in != `RSP_DELAYED |=> reason_code_q == `RC_INIT && chan_initial_q
  ) else $error("initial state reason missing");

  a_len_reason: assert property ( // [RULE6]
    clk_en && resp_req && !chan_initial_q && !cmd_unknown && len_bad &&
    resp_code_in != `RSP_DELAYED |=> reason_code_q == `RC_LEN
  ) else $error("length error reason missing");

  a_param_reason: assert property ( // [RULE3]
    clk_en && resp_req && !chan_initial_q && !cmd_unknown && !len_bad && param_bad &&
    resp_code_in != `RSP_DELAYED |=> reason_code_q == `RC_PARAM
  ) else $error("parameter error reason missing");

  a_hdr_inst_zero: assert property ( // [RULE11]
    pkt_valid_q && out_idx_q == `W_HDR0 |-> pkt_word_q[7:0] == `EVT_INST_ID &&
    pkt_word_q[31:24] == `EVT_MGR_ID
  ) else $error("event header identifiers not zero");

  a_msg_type_chan: assert property ( // [RULE12] [RULE13]
    pkt_valid_q && out_idx_q == `W_HDR1 |-> pkt_word_q[31:24] == `EVT_MSG_TYPE &&
    pkt_word_q[23:16] == chan_q
  ) else $error("event type field or channel id wrong");

  a_type_word: assert property ( // [RULE14]
    pkt_valid_q && out_idx_q == `W_TYPE |-> pkt_word_q == {24'h00_0000, type_q}
  ) else $error("event type word wrong");

  a_reserved_zero: assert property ( // [RULE16]
    pkt_valid_q && (out_idx_q == `W_RSV0 || out_idx_q == `W_RSV1) |->
    pkt_word_q == 32'h0000_0000
  ) else $error("reserved words not zero");

  // checked at the load: a new request may replace the format flag while the last word waits
  a_last_index: assert property ( // [RULE17]
    clk_en && state_q == PKT_SEND && can_load |=> pkt_valid_q &&
    pkt_last_q == (out_idx_q == (oem_q ? `W_LAST_OEM : `W_LAST_STD))
  ) else $error("packet ends at wrong word");

  a_word_hold: assert property ( // [RULE10]
    clk_en && pkt_valid_q && !pkt_ready |=> pkt_valid_q && $stable(pkt_word_q)
  ) else $error("stalled word changed");

endmodule // reason_code_and_event_packet_builder
`default_nettype wire

/* tb/pkt_sink.sv */
// packet sink standing in for the management controller
`timescale 1ns/100ps
`default_nettype none
module pkt_sink (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic pkt_valid_q,
  output logic pkt_ready
);
  // only takes words: no reply path exists, so an event is never acknowledged
  // every type code is taken alike, the meaning is left to software
  always @(negedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_ready <= 1'b0;
    end else begin
      pkt_ready <= (slow & pkt_valid_q) ? 1'($urandom % 2) : 1'b1;
    end
  end
endmodule // pkt_sink
`default_nettype wire

/* tb/reason_code_and_event_packet_builder_bench.sv */
// self-checking bench for the reason code selector and event packet builder
`timescale 1ns/100ps
`default_nettype none
`include "reason_event_regs.svh"
module reason_code_and_event_packet_builder_bench
  import reason_event_pkg::*;
;
  logic core_clk, rst_n, resp_req, cmd_unknown, evt_req, evt_oem, slow, ini, clk_en;
  logic [4:0] cnd;
  logic [7:0] cmd_type, event_type_code, own_chan_id;
  logic [15:0] resp_code_in, vendor_reason, resp_code_q, reason_code_q;
  word_t evt_data, mfr_id, pkt_word_q;
  logic resp_valid_q, chan_initial_q, evt_busy_q, evt_reject_q;
  logic pkt_valid_q, pkt_last_q, pkt_ready;
  logic [7:0] ty_l[9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h6f, 8'h70, 8'h80, 8'hff};
  int err_total, n_tests;
  logic [32:0] rq[$];
  logic [32:0] wq[$];
  logic [32:0] jq[$];

  reason_code_and_event_packet_builder dut (.core_clk(core_clk), .rst_n(rst_n),
    .clk_en(clk_en), .resp_req(resp_req), .cmd_type(cmd_type), .resp_code_in(resp_code_in),
    .cmd_unknown(cmd_unknown), .len_bad(cnd[4]), .param_bad(cnd[3]), .pkg_busy(cnd[2]),
    .chan_busy(cnd[1]), .info_na(cnd[0]), .vendor_reason(vendor_reason),
    .resp_valid_q(resp_valid_q), .resp_code_q(resp_code_q), .reason_code_q(reason_code_q),
    .chan_initial_q(chan_initial_q), .evt_req(evt_req), .evt_oem(evt_oem),
    .event_type_code(event_type_code), .evt_data(evt_data), .mfr_id(mfr_id),
    .own_chan_id(own_chan_id), .evt_busy_q(evt_busy_q), .evt_reject_q(evt_reject_q),
    .pkt_valid_q(pkt_valid_q), .pkt_word_q(pkt_word_q), .pkt_last_q(pkt_last_q),
    .pkt_ready(pkt_ready));
  pkt_sink sink (.core_clk(core_clk), .rst_n(rst_n), .slow(slow),
    .pkt_valid_q(pkt_valid_q), .pkt_ready(pkt_ready));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // comparison and closing
  // ----------------------------------------
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    check("leftover", 33'(rq.size() + wq.size() + jq.size()), 33'h0);
    $display("counts: %0d checks, %0d bad", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // an empty queue gives x as expected, so an unasked result always mismatches
  always @(posedge core_clk) begin
    // a frozen edge moves nothing, so it is no result
    if (rst_n === 1'b1 && clk_en === 1'b1) begin
      if (resp_valid_q === 1'b1) begin
        check("resp", {1'b0, resp_code_q, reason_code_q}, rq.size() ? rq.pop_front() : 'x);
      end
      if (pkt_valid_q === 1'b1 && pkt_ready === 1'b1) begin
        check("word", {pkt_last_q, pkt_word_q}, wq.size() ? wq.pop_front() : 'x);
      end
      if (evt_reject_q === 1'b1) begin
        check("reject", 33'h1, jq.size() ? jq.pop_front() : 'x);
      end
    end
  end

  // ----------------------------------------
  // drivers, called at a falling edge
  // ----------------------------------------
  task automatic resp(input logic [7:0] ct, input logic [15:0] rc, input logic unk,
                      input logic [4:0] c, input logic [15:0] vr);
    logic [15:0] r;
    cmd_type = ct;
    resp_code_in = rc;
    cmd_unknown = unk;
    cnd = c;
    vendor_reason = vr;
    resp_req = 1'b1;
    if (rc == `RSP_DELAYED) r = `RC_NONE;
    else if (ini && ct > `CMD_DESEL_PKG) r = `RC_INIT;
    else if (c[4]) r = `RC_LEN;
    else if (c[3]) r = `RC_PARAM;
    else if (c[2]) r = `RC_PKG_NR;
    else if (c[1]) r = `RC_CHAN_NR;
    else if (c[0]) r = `RC_INFO;
    else if (vr[`RC_VENDOR_BIT]) r = vr;
    else r = `RC_NONE;
    rq.push_back(unk ? {1'b0, `RSP_UNSUP, `RC_UNSUP} : {1'b0, rc, r});
    if (!unk && ct == `CMD_CLEAR_INIT) ini = 1'b0;
    if (!unk && ct == `CMD_RESET_CHAN) ini = 1'b1;
    @(negedge core_clk);
  endtask

  task automatic evt(input logic [7:0] ty, input logic oem);
    word_t w[8];
    logic [31:0] s;
    int k;
    k = 0;
    while (evt_busy_q !== 1'b0 && k < 60) begin
      @(negedge core_clk);
      k++;
    end
    own_chan_id = 8'($urandom);
    evt_data = $urandom;
    mfr_id = $urandom;
    event_type_code = ty;
    evt_oem = oem;
    evt_req = 1'b1;
    if (ty >= `EVT_RSV_LO && ty <= `EVT_RSV_HI) begin
      jq.push_back(33'h1);
    end else begin
      w[0] = {8'h00, `EVT_HDR_REV, 8'h00, `EVT_INST_ID};
      w[1] = {`EVT_MSG_TYPE, own_chan_id, 8'h00, oem ? `EVT_LEN_OEM : `EVT_LEN_STD};
      w[2] = 32'h0;
      w[3] = 32'h0;
      w[4] = {24'h000000, ty};
      w[5] = oem ? mfr_id : evt_data;
      w[6] = evt_data;
      s = 32'h0;
      for (int i = 0; i < (oem ? 7 : 6); i++) begin
        s += w[i][31:16] + w[i][15:0];
        wq.push_back({1'b0, w[i]});
      end
      wq.push_back({1'b1, -s});
    end
    @(negedge core_clk);
    evt_req = 1'b0;
    @(negedge core_clk);
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(7));
    {rst_n, resp_req, cmd_unknown, evt_req, evt_oem, slow, cnd} = '0;
    {cmd_type, event_type_code, own_chan_id, resp_code_in, vendor_reason} = '0;
    evt_data = 32'h0;
    mfr_id = 32'h0;
    ini = 1'b1;
    clk_en = 1'b1;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    check("reset", {resp_valid_q, reason_code_q, evt_busy_q, evt_reject_q, pkt_valid_q,
                    pkt_last_q}, 33'h0);
    check("initial", chan_initial_q, 33'h1);
    resp(8'h03, `RSP_OK, 1'b0, 5'h00, 16'h0000);
    resp(`CMD_SEL_PKG, `RSP_OK, 1'b0, 5'h00, 16'h0000);
    resp(`CMD_DESEL_PKG, `RSP_OK, 1'b0, 5'h10, 16'h0000);
    resp(8'h0a, `RSP_DELAYED, 1'b0, 5'h1f, 16'h8001);
    resp(8'h0a, 16'h0001, 1'b1, 5'h00, 16'h0000);
    resp(`CMD_CLEAR_INIT, `RSP_OK, 1'b0, 5'h00, 16'h0000);
    check("cleared", chan_initial_q, 33'h0);
    $display("test initial state done");
    for (int i = 0; i < 5; i++) resp(8'h0b, 16'h0001, 1'b0, 5'(1 << i), 16'h8000);
    resp(8'h10, 16'h0001, 1'b0, 5'h00, 16'h8123);
    resp(8'h10, `RSP_OK, 1'b0, 5'h00, 16'h7123);
    resp(`CMD_RESET_CHAN, `RSP_DELAYED, 1'b0, 5'h00, 16'h0000);
    resp(8'h0b, `RSP_OK, 1'b0, 5'h08, 16'h0000);
    resp(`CMD_CLEAR_INIT, `RSP_OK, 1'b0, 5'h00, 16'h0000);
    $display("test conditions done");
    // the model answers from the state before the request, as the logic does
    repeat (40) resp(8'($urandom), 16'($urandom % 5),
                     1'($urandom % 8 == 0), 5'($urandom), 16'($urandom));
    resp_req = 1'b0;
    $display("test random responses done");
    for (int m = 0; m < 2; m++) begin
      slow = 1'(m);
      for (int i = 0; i < 9; i++) evt(ty_l[i], 1'(i + m));
    end
    evt_req = 1'b1;
    event_type_code = 8'h01;
    @(negedge core_clk);
    evt_req = 1'b0;
    repeat (100) @(negedge core_clk);
    $display("test events done");
    evt(8'h70, 1'b0);
    // freeze mid-packet with a request standing: nothing may move until enable returns
    clk_en = 1'b0;
    resp(8'h0b, `RSP_OK, 1'b0, 5'h04, 16'h0000);
    repeat (3) @(negedge core_clk);
    check("frozen", {evt_busy_q, resp_valid_q}, 33'h2);
    clk_en = 1'b1;
    @(negedge core_clk);
    resp_req = 1'b0;
    repeat (40) @(negedge core_clk);
    $display("test clock enable done");
    tally_and_finish();
  end

  initial begin
    #500000;
    err_total++;
    tally_and_finish();
  end
endmodule // reason_code_and_event_packet_builder_bench
`default_nettype wire
